// ---- rtl/ncq_cfg.svh ----
// Offsets, field positions, reset values and timing counts for the shadow configuration block
`ifndef NCQ_CFG_SVH
`define NCQ_CFG_SVH

`define NCQ_REG_CD_GAIN 8'h0e
`define NCQ_REG_CD_GAIN_DLY 8'h0f
`define NCQ_REG_CD_TRIM 8'h11
`define NCQ_REG_AB_SHIFT 8'h12
`define NCQ_REG_CD_SHIFT 8'h13
`define NCQ_REG_AB_STEP_LO 8'h14
`define NCQ_REG_AB_STEP_HI 8'h15
`define NCQ_REG_CD_STEP_LO 8'h16
`define NCQ_REG_CD_STEP_HI 8'h17
`define NCQ_REG_SYNC_SEL 8'h1e
`define NCQ_REG_STATUS 8'h1f
`define NCQ_GAIN_RST 16'h0400
`define NCQ_GAIN_DLY_RST 16'h0400
`define NCQ_ZERO16 16'h0000
`define NCQ_TRIM_W 12
`define NCQ_BIT_CORR_SYNC 0
`define NCQ_BIT_MIX_SYNC 1
`define NCQ_SYNC_SEL_RST 2'h3
`define NCQ_SYNC_LATENCY 1

`endif

// ---- rtl/ncq_nco.sv ----
// One numerically controlled oscillator phase path
`timescale 1ns/100ps
module ncq_nco (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Active settings in, table address out
    ncq_nco_if.nco port_nco
);
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [15:0] addr_q;
    logic [15:0] addr_d;

    assign acc_d = acc_q + port_nco.step;
    assign addr_d = acc_q[31:16] + port_nco.shift;
    assign port_nco.table_addr = addr_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_q <= 32'h00000000;
            addr_q <= 16'h0000;
        end else begin
            acc_q <= acc_d;
            addr_q <= addr_d;
        end
    end
endmodule // ncq_nco

// ---- rtl/ncq_nco_if.sv ----
// Carrier between the register bank and one NCO lane
`timescale 1ns/100ps
interface ncq_nco_if;
    logic [15:0] shift;
    logic [31:0] step;
    logic [15:0] table_addr;
    modport bank (output shift, output step, input table_addr);
    modport nco (input shift, input step, output table_addr);
endinterface : ncq_nco_if

// ---- rtl/ncq_pkg.sv ----
// Types for the shadow configuration block
package ncq_pkg;
    typedef enum logic [1:0] {
        NCQ_W_IDLE,
        NCQ_W_RESP
    } ncq_wr_state_t;

    typedef struct packed {
        logic [15:0] shift;
        logic [31:0] step;
    } ncq_mix_t;
endpackage

// ---- rtl/ncq_shadow_cfg.sv ----
// Double-buffered correction and mixer configuration behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "ncq_cfg.svh"
module ncq_shadow_cfg (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // AXI4-Lite write address and data
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // AXI4-Lite write response
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Datapath samples
    input wire logic [15:0] i_sample_c,
    input wire logic [15:0] i_sample_d,
    output logic [15:0] o_sample_c,
    output logic [15:0] o_sample_d,
    // Active settings to the datapath
    output logic [15:0] o_cd_gain,
    output logic [15:0] o_cd_gain_dly,
    output logic [11:0] o_cd_iq_phase_trim,
    output logic [15:0] o_ab_table_addr,
    output logic [15:0] o_cd_table_addr
);
    ////////////////////////////////////////////////////////////////////////////
    // Write channel
    ncq_pkg::ncq_wr_state_t wst_q;
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] waddr_q;
    logic [15:0] wdat_q;
    logic wr_go;
    logic wr_ok;
    logic [7:0] aw_idx;
    logic [7:0] ar_idx;
    logic aw_take;
    logic w_take;
    logic wr_err_q;

    assign o_awready = (wst_q == ncq_pkg::NCQ_W_IDLE) && !aw_got_q;
    assign o_wready = (wst_q == ncq_pkg::NCQ_W_IDLE) && !w_got_q;
    assign aw_take = i_awvalid && o_awready;
    assign w_take = i_wvalid && o_wready;
    assign aw_idx = i_awaddr[9:2];
    assign wr_go = (wst_q == ncq_pkg::NCQ_W_IDLE) && (aw_got_q || aw_take) && (w_got_q || w_take);
    assign o_bvalid = (wst_q == ncq_pkg::NCQ_W_RESP);
    assign o_bresp = wr_err_q ? 2'h2 : 2'h0;

    logic [7:0] wa_now;
    logic [15:0] wd_now;
    assign wa_now = aw_got_q ? waddr_q : aw_idx;
    assign wd_now = w_got_q ? wdat_q : {(i_wstrb[1] ? i_wdata[15:8] : 8'h00),
                                        (i_wstrb[0] ? i_wdata[7:0] : 8'h00)};
    logic wstrb_full_q;
    logic wstrb_full;
    assign wstrb_full = w_got_q ? wstrb_full_q : (i_wstrb[1:0] == 2'h3);

    logic map_hit;
    assign map_hit = (wa_now == `NCQ_REG_CD_GAIN) || (wa_now == `NCQ_REG_CD_GAIN_DLY)
        || (wa_now == `NCQ_REG_CD_TRIM) || (wa_now == `NCQ_REG_AB_SHIFT)
        || (wa_now == `NCQ_REG_CD_SHIFT) || (wa_now == `NCQ_REG_AB_STEP_LO)
        || (wa_now == `NCQ_REG_AB_STEP_HI) || (wa_now == `NCQ_REG_CD_STEP_LO)
        || (wa_now == `NCQ_REG_CD_STEP_HI) || (wa_now == `NCQ_REG_SYNC_SEL);
    assign wr_ok = wr_go && map_hit && wstrb_full;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wst_q <= ncq_pkg::NCQ_W_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 8'h00;
            wdat_q <= 16'h0000;
            wstrb_full_q <= 1'b0;
            wr_err_q <= 1'b0;
        end else begin
            case (wst_q)
                ncq_pkg::NCQ_W_IDLE: begin
                    if (wr_go) begin
                        wst_q <= ncq_pkg::NCQ_W_RESP;
                        aw_got_q <= 1'b0;
                        w_got_q <= 1'b0;
                        wr_err_q <= !map_hit;
                    end else begin
                        if (aw_take) begin
                            aw_got_q <= 1'b1;
                            waddr_q <= aw_idx;
                        end
                        if (w_take) begin
                            w_got_q <= 1'b1;
                            wdat_q <= wd_now;
                            wstrb_full_q <= (i_wstrb[1:0] == 2'h3);
                        end
                    end
                end
                ncq_pkg::NCQ_W_RESP: begin
                    if (i_bready) begin
                        wst_q <= ncq_pkg::NCQ_W_IDLE;
                    end
                end
                default: wst_q <= ncq_pkg::NCQ_W_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Staged registers
    logic [15:0] st_cd_gain_q;
    logic [15:0] st_cd_gain_dly_q;
    logic [11:0] st_cd_trim_q;
    logic [15:0] st_ab_shift_q;
    logic [15:0] st_cd_shift_q;
    logic [31:0] st_ab_step_q;
    logic [31:0] st_cd_step_q;
    logic [1:0] sync_sel_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_cd_gain_q <= `NCQ_GAIN_RST;
            st_cd_gain_dly_q <= `NCQ_GAIN_DLY_RST;
            st_cd_trim_q <= 12'h000;
            st_ab_shift_q <= `NCQ_ZERO16;
            st_cd_shift_q <= `NCQ_ZERO16;
            st_ab_step_q <= 32'h00000000;
            st_cd_step_q <= 32'h00000000;
            sync_sel_q <= `NCQ_SYNC_SEL_RST;
        end else if (wr_ok) begin
            case (wa_now)
                `NCQ_REG_CD_GAIN: st_cd_gain_q <= wd_now;
                `NCQ_REG_CD_GAIN_DLY: st_cd_gain_dly_q <= wd_now;
                `NCQ_REG_CD_TRIM: st_cd_trim_q <= wd_now[11:0];
                `NCQ_REG_AB_SHIFT: st_ab_shift_q <= wd_now;
                `NCQ_REG_CD_SHIFT: st_cd_shift_q <= wd_now;
                `NCQ_REG_AB_STEP_LO: st_ab_step_q[15:0] <= wd_now;
                `NCQ_REG_AB_STEP_HI: st_ab_step_q[31:16] <= wd_now;
                `NCQ_REG_CD_STEP_LO: st_cd_step_q[15:0] <= wd_now;
                `NCQ_REG_CD_STEP_HI: st_cd_step_q[31:16] <= wd_now;
                `NCQ_REG_SYNC_SEL: sync_sel_q <= wd_now[1:0];
                default: st_cd_gain_q <= st_cd_gain_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto-sync into active copies
    logic corr_sync_q;
    logic ab_sync_q;
    logic cd_sync_q;
    logic corr_sync_d;
    logic ab_sync_d;
    logic cd_sync_d;
    assign corr_sync_d = wr_ok && (wa_now == `NCQ_REG_CD_TRIM)
        && sync_sel_q[`NCQ_BIT_CORR_SYNC];
    assign ab_sync_d = wr_ok && (wa_now == `NCQ_REG_AB_SHIFT)
        && sync_sel_q[`NCQ_BIT_MIX_SYNC];
    assign cd_sync_d = wr_ok && (wa_now == `NCQ_REG_CD_SHIFT)
        && sync_sel_q[`NCQ_BIT_MIX_SYNC];

    ncq_pkg::ncq_mix_t ab_act_q;
    ncq_pkg::ncq_mix_t cd_act_q;
    logic [15:0] act_cd_gain_q;
    logic [15:0] act_cd_gain_dly_q;
    logic [11:0] act_cd_trim_q;
    logic [1:0] sync_seen_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            corr_sync_q <= 1'b0;
            ab_sync_q <= 1'b0;
            cd_sync_q <= 1'b0;
        end else begin
            corr_sync_q <= corr_sync_d;
            ab_sync_q <= ab_sync_d;
            cd_sync_q <= cd_sync_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            act_cd_gain_q <= `NCQ_GAIN_RST;
            act_cd_gain_dly_q <= `NCQ_GAIN_DLY_RST;
            act_cd_trim_q <= 12'h000;
            ab_act_q <= '0;
            cd_act_q <= '0;
        end else begin
            if (corr_sync_q) begin
                act_cd_gain_q <= st_cd_gain_q;
                act_cd_gain_dly_q <= st_cd_gain_dly_q;
                act_cd_trim_q <= st_cd_trim_q;
            end
            if (ab_sync_q) begin
                ab_act_q <= '{shift: st_ab_shift_q, step: st_ab_step_q};
            end
            if (cd_sync_q) begin
                cd_act_q <= '{shift: st_cd_shift_q, step: st_cd_step_q};
            end
        end
    end

    // Sticky record of syncs, cleared by writing the status register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_seen_q <= 2'h0;
        end else begin
            sync_seen_q <= ((wr_go && (wa_now == `NCQ_REG_STATUS)) ? 2'h0 : sync_seen_q)
                | {ab_sync_q || cd_sync_q, corr_sync_q};
        end
    end

    assign o_cd_gain = act_cd_gain_q;
    assign o_cd_gain_dly = act_cd_gain_dly_q;
    assign o_cd_iq_phase_trim = act_cd_trim_q;

    ////////////////////////////////////////////////////////////////////////////
    // Phase correction datapath
    logic signed [27:0] trim_prod;
    logic signed [16:0] c_sum;
    logic [15:0] c_q;
    logic [15:0] d_q;
    assign trim_prod = $signed(act_cd_trim_q) * $signed(i_sample_d);
    assign c_sum = $signed({i_sample_c[15], i_sample_c})
        + $signed({trim_prod[27], trim_prod[27:12]});

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            c_q <= 16'h0000;
            d_q <= 16'h0000;
        end else begin
            c_q <= (c_sum[16] != c_sum[15]) ? {c_sum[16], {15{~c_sum[16]}}} : c_sum[15:0];
            d_q <= i_sample_d;
        end
    end
    assign o_sample_c = c_q;
    assign o_sample_d = d_q;

    ////////////////////////////////////////////////////////////////////////////
    // NCO lanes
    ncq_nco_if ab_lane ();
    ncq_nco_if cd_lane ();
    assign ab_lane.shift = ab_act_q.shift;
    assign ab_lane.step = ab_act_q.step;
    assign cd_lane.shift = cd_act_q.shift;
    assign cd_lane.step = cd_act_q.step;

    ncq_nco u_ab_nco (.i_clk(i_clk), .i_resetn(i_resetn), .port_nco(ab_lane));
    ncq_nco u_cd_nco (.i_clk(i_clk), .i_resetn(i_resetn), .port_nco(cd_lane));
    assign o_ab_table_addr = ab_lane.table_addr;
    assign o_cd_table_addr = cd_lane.table_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic rerr_q;
    logic [15:0] rd_val;
    logic rd_hit;
    assign ar_idx = i_araddr[9:2];
    assign o_arready = !rvalid_q;
    assign rd_hit = (ar_idx == `NCQ_REG_CD_GAIN) || (ar_idx == `NCQ_REG_CD_GAIN_DLY)
        || (ar_idx == `NCQ_REG_CD_TRIM) || (ar_idx == `NCQ_REG_AB_SHIFT)
        || (ar_idx == `NCQ_REG_CD_SHIFT) || (ar_idx == `NCQ_REG_AB_STEP_LO)
        || (ar_idx == `NCQ_REG_AB_STEP_HI) || (ar_idx == `NCQ_REG_CD_STEP_LO)
        || (ar_idx == `NCQ_REG_CD_STEP_HI) || (ar_idx == `NCQ_REG_SYNC_SEL)
        || (ar_idx == `NCQ_REG_STATUS);
    assign rd_val =
        (ar_idx == `NCQ_REG_CD_GAIN) ? st_cd_gain_q :
        (ar_idx == `NCQ_REG_CD_GAIN_DLY) ? st_cd_gain_dly_q :
        (ar_idx == `NCQ_REG_CD_TRIM) ? {4'h0, st_cd_trim_q} :
        (ar_idx == `NCQ_REG_AB_SHIFT) ? st_ab_shift_q :
        (ar_idx == `NCQ_REG_CD_SHIFT) ? st_cd_shift_q :
        (ar_idx == `NCQ_REG_AB_STEP_LO) ? st_ab_step_q[15:0] :
        (ar_idx == `NCQ_REG_AB_STEP_HI) ? st_ab_step_q[31:16] :
        (ar_idx == `NCQ_REG_CD_STEP_LO) ? st_cd_step_q[15:0] :
        (ar_idx == `NCQ_REG_CD_STEP_HI) ? st_cd_step_q[31:16] :
        (ar_idx == `NCQ_REG_SYNC_SEL) ? {14'h0000, sync_sel_q} :
        (ar_idx == `NCQ_REG_STATUS) ? {14'h0000, sync_seen_q} : 16'h0000;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rerr_q <= 1'b0;
        end else if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_val};
            rerr_q <= !rd_hit;
        end else if (i_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rerr_q ? 2'h2 : 2'h0;
endmodule // ncq_shadow_cfg

// ---- tb/ncq_shadow_cfg_properties.sv ----
// Bus and datapath properties of the shadow configuration block
`timescale 1ns/100ps
module ncq_shadow_cfg_properties (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Bus handshakes
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    // Datapath
    input wire logic [15:0] i_sample_c,
    input wire logic [15:0] i_sample_d,
    input wire logic [15:0] o_sample_c,
    input wire logic [15:0] o_sample_d,
    input wire logic [15:0] o_cd_gain,
    input wire logic [11:0] o_cd_iq_phase_trim
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////
    sequence wr_both;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence rd_take;
        i_arvalid && o_arready;
    endsequence
    AST_B_AFTER_BOTH: assert property (wr_both |=> o_bvalid)
        else $error("no write response after address and data");
    AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response not held");
    AST_NO_TAKE_PENDING: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write channel ready while response pending");
    AST_R_AFTER_AR: assert property (rd_take |=> o_rvalid)
        else $error("no read data one cycle after address");
    AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
    AST_D_DELAY: assert property (1'b1 |=> o_sample_d == $past(i_sample_d))
        else $error("D sample not passed with one cycle delay");
    AST_C_ZERO_TRIM: assert property (o_cd_iq_phase_trim == 12'h000 |=> o_sample_c == $past(i_sample_c))
        else $error("C sample altered with zero trim");
    AST_ACTIVE_AFTER_RESP: assert property ($changed(o_cd_gain) || $changed(o_cd_iq_phase_trim) |-> $past(o_bvalid))
        else $error("active correction changed without a write");
endmodule // ncq_shadow_cfg_properties

// ---- tb/test_ncq_shadow_cfg.sv ----
// Self-checking bench for the shadow configuration block
`timescale 1ns/100ps
module test_ncq_shadow_cfg;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] sc = '0, sd = '0, osc, osd, gain, gdly, abt, cdt;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [11:0] trim;
    int err_count = 0;
    int compares = 0;

    always #20 i_clk = ~i_clk;

    ncq_shadow_cfg ncq_shadow_cfg_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_sample_c(sc), .i_sample_d(sd), .o_sample_c(osc),
        .o_sample_d(osd), .o_cd_gain(gain), .o_cd_gain_dly(gdly),
        .o_cd_iq_phase_trim(trim), .o_ab_table_addr(abt), .o_cd_table_addr(cdt));

    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results;
        $display("Mismatches %0d, compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic tmo(input logic ok);
        if (!ok) begin
            err_count++;
            $display("ERROR response expected 1 seen 0");
            results();
        end
    endtask

    task automatic wr(input logic [7:0] ix, input logic [15:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, bv;
        n = 0;
        bv = 1'b0;
        @(posedge i_clk);
        awaddr <= {22'h0, ix, 2'b00};
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!bv && n < 40) begin
            @(negedge i_clk);
            bv = bvalid;
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge i_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        tmo(bv);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b1;
        @(posedge i_clk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ix, input logic [31:0] e, input logic [1:0] er);
        int n;
        logic ta, rv;
        n = 0;
        rv = 1'b0;
        @(posedge i_clk);
        araddr <= {22'h0, ix, 2'b00};
        arvalid <= 1'b1;
        while (!rv && n < 40) begin
            @(negedge i_clk);
            rv = rvalid;
            ta = arvalid && arready;
            @(posedge i_clk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        tmo(rv);
        chk($sformatf("reg %h", ix), e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b1;
        @(posedge i_clk);
        rready <= 1'b0;
    endtask

    task automatic samp(input logic [15:0] c, input logic [15:0] d, input logic [15:0] e);
        @(posedge i_clk);
        sc <= c;
        sd <= d;
        @(posedge i_clk);
        @(negedge i_clk);
        chk("sample_c", {16'h0, e}, {16'h0, osc});
        chk("sample_d", {16'h0, d}, {16'h0, osd});
    endtask

    // Table address movement over two cycles
    task automatic mov(input logic cd, input logic [15:0] e);
        logic [15:0] a0;
        @(negedge i_clk);
        a0 = cd ? cdt : abt;
        repeat (2) @(negedge i_clk);
        chk("table_step", {16'h0, e}, {16'h0, (cd ? cdt : abt) - a0});
    endtask

    ////////////////////////////////////////
    task automatic t_reset;
        for (int i = 17; i < 21; i++) begin
            rd(i[7:0], 32'h0, 2'h0);
        end
        rd(8'h1e, 32'h3, 2'h0);
        wr(8'h20, 16'h5a5a, 2'h2);
        rd(8'h20, 32'h0, 2'h2);
        samp(16'h1234, 16'h4000, 16'h1234);
    endtask

    task automatic t_corr;
        wr(8'h0e, 16'h0123, 2'h0);
        wr(8'h0f, 16'h0456, 2'h0);
        @(negedge i_clk);
        chk("gain", 32'h0400, {16'h0, gain});
        chk("gain_dly", 32'h0400, {16'h0, gdly});
        wr(8'h11, 16'h0100, 2'h0);
        @(negedge i_clk);
        chk("gain", 32'h0123, {16'h0, gain});
        chk("gain_dly", 32'h0456, {16'h0, gdly});
        chk("trim", 32'h100, {20'h0, trim});
        samp(16'h0100, 16'h1000, 16'h0200);
        wr(8'h1e, 16'h0000, 2'h0);
        wr(8'h11, 16'h0800, 2'h0);
        samp(16'h0100, 16'h1000, 16'h0200);
        wr(8'h1e, 16'h0003, 2'h0);
        wr(8'h11, 16'h0800, 2'h0);
        samp(16'h1000, 16'h1000, 16'h0800);
    endtask

    task automatic t_mix;
        wr(8'h12, 16'h1234, 2'h0);
        @(negedge i_clk);
        chk("ab_addr", 32'h1234, {16'h0, abt});
        wr(8'h14, 16'h8000, 2'h0);
        mov(1'b0, 16'h0000);
        wr(8'h12, 16'h1234, 2'h0);
        mov(1'b0, 16'h0001);
        wr(8'h14, 16'h0000, 2'h0);
        wr(8'h15, 16'hffff, 2'h0);
        wr(8'h12, 16'h1234, 2'h0);
        mov(1'b0, 16'hfffe);
        wr(8'h13, 16'h0010, 2'h0);
        @(negedge i_clk);
        chk("cd_addr", 32'h0010, {16'h0, cdt});
        wr(8'h17, 16'h0002, 2'h0);
        mov(1'b1, 16'h0000);
        wr(8'h13, 16'h0010, 2'h0);
        mov(1'b1, 16'h0004);
        rd(8'h1f, 32'h3, 2'h0);
        wr(8'h1f, 16'h0000, 2'h2);
        rd(8'h1f, 32'h0, 2'h0);
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_reset();
        t_corr();
        t_mix();
        results();
    end
endmodule // test_ncq_shadow_cfg

bind ncq_shadow_cfg ncq_shadow_cfg_properties ncq_shadow_cfg_properties_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_rdata(o_rdata), .i_sample_c(i_sample_c),
    .i_sample_d(i_sample_d), .o_sample_c(o_sample_c), .o_sample_d(o_sample_d),
    .o_cd_gain(o_cd_gain), .o_cd_iq_phase_trim(o_cd_iq_phase_trim));
